// *** src/efb_pkg.sv ***
package efb_pkg;

  // bank width default and the widest bank one data word can show
  localparam int unsigned EFB_WIDTH_DEF = 8;
  localparam int unsigned EFB_WIDTH_MAX = 32;

  // register bus geometry
  localparam int unsigned EFB_ADDR_W = 4;
  localparam int unsigned EFB_DATA_W = 32;

  // register byte offsets
  localparam logic [3:0] EFB_ADDR_CTRL = 4'h0; // bank_ctrl
  localparam logic [3:0] EFB_ADDR_STATE = 4'h4; // bank_state
  localparam logic [3:0] EFB_ADDR_KNOWN = 4'h8; // bank_known
  localparam logic [3:0] EFB_ADDR_STATUS = 4'hC; // bank_status

  // bank_status field positions
  localparam int unsigned EFB_STAT_UNSTABLE = 0;
  localparam int unsigned EFB_STAT_CLK = 1;

  // axi response codes
  localparam logic [1:0] EFB_RESP_OKAY = 2'h0;
  localparam logic [1:0] EFB_RESP_SLVERR = 2'h2;

  // bank variant, held in bank_ctrl bits 1:0
  typedef enum logic [1:0] {
    EFB_RISE_D = 2'b00,  // rising_d_bank
    EFB_FALL_JK = 2'b01, // falling_jk_bank
    EFB_DUAL_D = 2'b10,  // dual_edge_d_bank
    EFB_DUAL_JK = 2'b11  // dual_edge_jk_bank
  } efb_variant_t;

  localparam efb_variant_t EFB_CTRL_RESET = EFB_RISE_D;

  // read channel state
  typedef enum logic [0:0] {
    EFB_RD_IDLE = 1'b0, // waiting for an address
    EFB_RD_RESP = 1'b1  // data offered
  } efb_rd_state_t;

  // next value of one j-k bit on an active edge
  function automatic logic efb_jk_next(input logic q, input logic j,
                                       input logic k);
    logic r;
    r = q;
    case ({j, k})
      2'b00: r = q;     // hold
      2'b01: r = 1'b0;  // clear
      2'b10: r = 1'b1;  // set
      default: r = ~q;  // toggle
    endcase
    return r;
  endfunction : efb_jk_next

  // whether the j-k action leaves a bit with a known value
  function automatic logic efb_jk_known(input logic kn, input logic j,
                                        input logic k);
    return (j ^ k) | kn;
  endfunction : efb_jk_known

endpackage : efb_pkg

// *** src/efb_reg_if.sv ***
`timescale 1ns/1ps
// register access strobes between bus slave and bank
interface efb_reg_if;
  import efb_pkg::*;
  logic wr_en;                     // one-cycle write strobe
  logic [EFB_ADDR_W-1:0] wr_addr;  // write byte address
  logic [EFB_DATA_W-1:0] wr_data;  // write data
  logic [3:0] wr_strb;             // write byte enables
  logic wr_err;                    // write hit no register
  logic rd_en;                     // one-cycle read strobe
  logic [EFB_ADDR_W-1:0] rd_addr;  // read byte address
  logic [EFB_DATA_W-1:0] rd_data;  // read data, same cycle
  logic rd_err;                    // read hit no register

  modport slave (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_err, rd_data, rd_err
  );
  modport regs (
    input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_err, rd_data, rd_err
  );
endinterface : efb_reg_if

// *** src/efb_axil_slave.sv ***
`timescale 1ns/1ps
// axi4-lite slave turning bus traffic into register strobes
module efb_axil_slave
  import efb_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [efb_pkg::EFB_ADDR_W-1:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [efb_pkg::EFB_DATA_W-1:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // write strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [efb_pkg::EFB_ADDR_W-1:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [efb_pkg::EFB_DATA_W-1:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  efb_reg_if.slave regs // register strobes
);
  import efb_pkg::*;

  logic aw_have_q, aw_have_d; // write address held
  logic w_have_q, w_have_d; // write data held
  logic [EFB_ADDR_W-1:0] awaddr_q, awaddr_d; // held address
  logic [EFB_DATA_W-1:0] wdata_q, wdata_d; // held data
  logic [3:0] wstrb_q, wstrb_d; // held strobes
  logic bvalid_q, bvalid_d; // response pending
  logic [1:0] bresp_q, bresp_d; // response code
  efb_rd_state_t rd_q, rd_d; // read channel state
  logic [EFB_DATA_W-1:0] rdata_q, rdata_d; // read data out
  logic [1:0] rresp_q, rresp_d; // read response code
  logic do_wr; // commit write this cycle
  logic ar_take; // read address taken

  // channel readies and strobes
  always_comb begin
    s_awready = ~aw_have_q;
    s_wready = ~w_have_q;
    s_arready = (rd_q == EFB_RD_IDLE);
    do_wr = aw_have_q & w_have_q & ~bvalid_q;
    ar_take = s_arvalid & s_arready;
    regs.wr_en = do_wr;
    regs.wr_addr = awaddr_q;
    regs.wr_data = wdata_q;
    regs.wr_strb = wstrb_q;
    regs.rd_en = ar_take;
    regs.rd_addr = s_araddr;
  end

  // next values of both channels
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rd_d = rd_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_awvalid && s_awready) begin // capture address
      aw_have_d = 1'b1;
      awaddr_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin // capture data
      w_have_d = 1'b1;
      wdata_d = s_wdata;
      wstrb_d = s_wstrb;
    end
    if (s_bvalid && s_bready) begin // response taken
      bvalid_d = 1'b0;
    end
    if (do_wr) begin // write done, answer next cycle
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = regs.wr_err ? EFB_RESP_SLVERR : EFB_RESP_OKAY;
    end
    case (rd_q)
      EFB_RD_IDLE: begin
        if (ar_take) begin // sample data with the address
          rd_d = EFB_RD_RESP;
          rdata_d = regs.rd_data;
          rresp_d = regs.rd_err ? EFB_RESP_SLVERR : EFB_RESP_OKAY;
        end
      end
      EFB_RD_RESP: begin
        if (s_rready) begin // data taken
          rd_d = EFB_RD_IDLE;
        end
      end
      default: rd_d = EFB_RD_IDLE;
    endcase
  end

  // registers of both channels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= EFB_RESP_OKAY;
      rd_q <= EFB_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= EFB_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rd_q <= rd_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_rvalid = (rd_q == EFB_RD_RESP);
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;

endmodule : efb_axil_slave

// *** src/efb_bank.sv ***
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Contract
// - d bank loads only on rising bank clock
// - jk bank acts only on falling bank clock
// - dual banks act on selected edges
// - width parameter, shared preset, clear, clock
// - one rise and fall enable for all
// - clear forces zero, preset forces one
// - both low drive both outputs high
// - d loads on rise, holds when static
// - jk hold, clear, set, toggle on fall
// - dual d loads on enabled edges only
// - dual jk acts on enabled edges only
// - bits unknown until preset, clear, d load or jk set or clear
module efb_bank
  import efb_pkg::*;
#(
  parameter int unsigned N = efb_pkg::EFB_WIDTH_DEF // bank width
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [efb_pkg::EFB_ADDR_W-1:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [efb_pkg::EFB_DATA_W-1:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // write strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [efb_pkg::EFB_ADDR_W-1:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [efb_pkg::EFB_DATA_W-1:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  input wire logic bank_clock, // shared bank clock, sampled
  input wire logic async_preset_n, // shared preset, active low
  input wire logic async_clear_n, // shared clear, active low
  input wire logic rise_edge_enable, // dual banks: act on rise
  input wire logic fall_edge_enable, // dual banks: act on fall
  input wire logic [N-1:0] d_in, // d inputs
  input wire logic [N-1:0] j_in, // j inputs
  input wire logic [N-1:0] k_in, // k inputs
  output logic [N-1:0] q_out, // true outputs
  output logic [N-1:0] q_n_out, // complementary outputs
  output logic [N-1:0] bit_known, // bit holds a defined value
  output logic unstable // preset and clear both low
);
  import efb_pkg::*;

  // refuse widths the bank_state word cannot show
  if (N < 1 || N > EFB_WIDTH_MAX) begin : g_bad_width
    $error("efb_bank: N must lie in 1..32");
  end

  efb_reg_if regs (); // strobes from the bus slave

  efb_variant_t ctrl_q, ctrl_d; // selected bank variant
  logic [N-1:0] state_q, state_d; // stored bits
  logic [N-1:0] known_q, known_d; // bits with a defined value
  logic clk_prev_q, clk_prev_d; // bank clock one cycle back
  logic prev_ok_q, prev_ok_d; // clk_prev_q is meaningful
  logic clk_rise; // bank clock rose this cycle
  logic clk_fall; // bank clock fell this cycle
  logic fire; // active edge for selected variant
  logic is_jk; // variant uses j-k inputs
  logic pre_on; // preset alone asserted
  logic clr_on; // clear alone asserted
  logic both_on; // preset and clear together
  logic [N-1:0] q_view; // true output after preset and clear overrides
  logic [EFB_DATA_W-1:0] word_state; // state zero-extended
  logic [EFB_DATA_W-1:0] word_known; // known mask zero-extended

  // bus slave front end
  efb_axil_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .regs(regs.slave)
  );

  // preset and clear decode, shared by every bit
  always_comb begin
    both_on = ~async_preset_n & ~async_clear_n;
    clr_on = async_preset_n & ~async_clear_n;
    pre_on = ~async_preset_n & async_clear_n;
  end

  // edge detect on the sampled bank clock
  always_comb begin
    clk_rise = prev_ok_q & bank_clock & ~clk_prev_q;
    clk_fall = prev_ok_q & ~bank_clock & clk_prev_q;
    is_jk = (ctrl_q == EFB_FALL_JK) || (ctrl_q == EFB_DUAL_JK);
    case (ctrl_q)
      EFB_RISE_D: fire = clk_rise;
      EFB_FALL_JK: fire = clk_fall;
      EFB_DUAL_D, EFB_DUAL_JK: begin
        fire = (clk_rise & rise_edge_enable) |
               (clk_fall & fall_edge_enable);
      end
      default: fire = 1'b0;
    endcase
  end

  // next value of stored bits and known mask
  always_comb begin
    state_d = state_q;
    known_d = known_q;
    clk_prev_d = bank_clock;
    prev_ok_d = 1'b1;
    if (both_on) begin // unstable: value lost on release
      known_d = '0;
    end else if (clr_on) begin // forced low
      state_d = '0;
      known_d = '1;
    end else if (pre_on) begin // forced high
      state_d = '1;
      known_d = '1;
    end else if (fire) begin // active edge, static clock holds
      for (int i = 0; i < N; i++) begin
        if (is_jk) begin
          state_d[i] = efb_jk_next(state_q[i], j_in[i], k_in[i]);
          known_d[i] = efb_jk_known(known_q[i], j_in[i], k_in[i]);
        end else begin
          state_d[i] = d_in[i];
          known_d[i] = 1'b1;
        end
      end
    end
  end

  // bank_ctrl write
  always_comb begin
    ctrl_d = ctrl_q;
    if (regs.wr_en && regs.wr_addr == EFB_ADDR_CTRL &&
        regs.wr_strb[0]) begin
      ctrl_d = efb_variant_t'(regs.wr_data[1:0]);
    end
  end

  // write decode: unmapped offsets answer with an error
  always_comb begin
    case (regs.wr_addr)
      EFB_ADDR_CTRL, EFB_ADDR_STATE,
      EFB_ADDR_KNOWN, EFB_ADDR_STATUS: regs.wr_err = 1'b0;
      default: regs.wr_err = 1'b1;
    endcase
  end

  // read mux, narrow fields in the low bits
  always_comb begin
    word_state = '0;
    word_known = '0;
    word_state[N-1:0] = state_q;
    word_known[N-1:0] = known_q;
    regs.rd_data = '0;
    regs.rd_err = 1'b0;
    case (regs.rd_addr)
      EFB_ADDR_CTRL: regs.rd_data[1:0] = ctrl_q;
      EFB_ADDR_STATE: regs.rd_data = word_state;
      EFB_ADDR_KNOWN: regs.rd_data = word_known;
      EFB_ADDR_STATUS: begin // live pin view
        regs.rd_data[EFB_STAT_UNSTABLE] = both_on;
        regs.rd_data[EFB_STAT_CLK] = bank_clock;
      end
      default: regs.rd_err = regs.rd_en; // unmapped, flagged on a read
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= EFB_CTRL_RESET;
      state_q <= '0;
      known_q <= '0;
      clk_prev_q <= 1'b0;
      prev_ok_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      known_q <= known_d;
      clk_prev_q <= clk_prev_d;
      prev_ok_q <= prev_ok_d;
    end
  end

  // outputs: preset and clear override without waiting for clk
  always_comb begin
    if (clr_on) begin
      q_view = '0;
    end else if (pre_on || both_on) begin
      q_view = '1;
    end else begin
      q_view = state_q;
    end
    q_out = q_view;
    q_n_out = both_on ? '1 : ~q_view;
    bit_known = (clr_on || pre_on) ? '1 : known_q;
    unstable = both_on;
  end

endmodule : efb_bank

// *** sim/efb_bank_monitor.sv ***
`timescale 1ns/1ps
// port-level checks of the bank pins and the bus answers
module efb_bank_monitor #(
  parameter int unsigned N = 8 // bank width
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic s_awvalid, // write address valid
  input wire logic s_awready, // write address ready
  input wire logic s_wvalid, // write data valid
  input wire logic s_wready, // write data ready
  input wire logic s_bvalid, // write response valid
  input wire logic s_arvalid, // read address valid
  input wire logic s_arready, // read address ready
  input wire logic s_rvalid, // read data valid
  input wire logic bank_clock, // bank clock pin
  input wire logic async_preset_n, // preset, active low
  input wire logic async_clear_n, // clear, active low
  input wire logic [N-1:0] q_out, // true outputs
  input wire logic [N-1:0] q_n_out, // complements
  input wire logic [N-1:0] bit_known, // defined bits
  input wire logic unstable // both forces low
);
  logic pins_hi; // neither force active
  assign pins_hi = async_preset_n && async_clear_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // forced outputs
  AST_CLR_FORCE: assert property (
    !async_clear_n && async_preset_n |-> q_out == '0 && q_n_out == '1)
    else $error("clear did not force zero");
  AST_PRE_FORCE: assert property (
    !async_preset_n && async_clear_n |-> q_out == '1 && q_n_out == '0)
    else $error("preset did not force one");
  AST_BOTH_LOW: assert property (
    !async_preset_n && !async_clear_n |->
      q_out == '1 && q_n_out == '1 && unstable)
    else $error("both low not all high");
  AST_UNSTABLE: assert property (
    unstable |-> !async_preset_n && !async_clear_n)
    else $error("unstable flag without cause");
  AST_COMPL: assert property (
    async_preset_n || async_clear_n |-> q_n_out == ~q_out)
    else $error("complement mismatch");
  // no state change without a clock level change
  AST_STATIC_HOLD: assert property (
    $stable(bank_clock) && pins_hi |=> !pins_hi || $stable(q_out))
    else $error("state moved on static clock");
  AST_KNOWN_FORCE: assert property (
    async_preset_n != async_clear_n |-> bit_known == '1)
    else $error("forced bits not known");
  AST_KNOWN_DROP: assert property (
    !async_preset_n && !async_clear_n ##1
      async_preset_n == async_clear_n |-> bit_known == '0)
    else $error("known kept after both low");
  // bus answer timing
  AST_B_LATENCY: assert property (
    s_awvalid && s_awready && s_wvalid && s_wready && !s_bvalid |->
      ##1 !s_bvalid ##1 s_bvalid)
    else $error("write response late");
  AST_R_LATENCY: assert property (
    s_arvalid && s_arready |=> s_rvalid && !s_arready)
    else $error("read data late");
  cover property (!async_preset_n && !async_clear_n);
  cover property ($changed(bank_clock) && pins_hi ##1 $changed(q_out));
  cover property (s_bvalid && s_rvalid == 1'b0);
endmodule : efb_bank_monitor

bind efb_bank efb_bank_monitor #(.N(N)) efb_bank_monitor_i (.clk, .rst_n,
  .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_arvalid,
  .s_arready, .s_rvalid, .bank_clock, .async_preset_n, .async_clear_n,
  .q_out, .q_n_out, .bit_known, .unstable);

// *** sim/efb_pins_model.sv ***
`timescale 1ns/1ps
// bank clock source: one level change per step, level held between
module efb_pins_model (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic step, // request one level change
  output logic bank_clock // bank clock pin
);
  logic lvl_q; // present level
  logic lvl_d; // next level
  assign bank_clock = lvl_q;
  // next level
  always_comb begin
    lvl_d = lvl_q;
    if (!rst_n) lvl_d = 1'b0;
    else if (step) lvl_d = ~lvl_q;
  end
  // register level
  always_ff @(posedge clk) begin
    lvl_q <= lvl_d;
  end
endmodule : efb_pins_model

// *** sim/test_edge_flip_flop_bank.sv ***
`timescale 1ns/1ps
// self-checking bench for the flip-flop bank
module test_edge_flip_flop_bank;
  import efb_pkg::*;
  localparam int unsigned N = 8; // bank width
  logic clk, rst_n, step; // clock, reset, clock step
  logic [3:0] s_awaddr, s_araddr, s_wstrb; // addresses, strobes
  logic [31:0] s_wdata, s_rdata, rd, outs; // data, packed outputs
  logic [1:0] s_bresp, s_rresp, rs; // responses
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready; // read handshakes
  logic bank_clock, async_preset_n, async_clear_n; // shared pins
  logic rise_edge_enable, fall_edge_enable; // edge enables
  logic [N-1:0] d_in, j_in, k_in, q_out, q_n_out, bit_known; // bits
  logic unstable; // both forces low
  int bad_count, check_count, cyc; // tallies, cycles
  assign outs = {q_out, q_n_out, bit_known, 7'h00, unstable};
  efb_bank #(.N(N)) efb_bank_i (.clk, .rst_n, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .bank_clock, .async_preset_n,
    .async_clear_n, .rise_edge_enable, .fall_edge_enable, .d_in, .j_in,
    .k_in, .q_out, .q_n_out, .bit_known, .unstable);
  efb_pins_model efb_pins_model_i (.clk, .rst_n, .step, .bank_clock);
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // report and stop
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      bad_count++;
      wrap_up();
    end
  end
  // bus write, each channel released when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      pa = pa && !s_awready;
      pw = pw && !s_wready;
      @(posedge clk);
      if (!pa) s_awvalid <= 1'b0;
      if (!pw) s_wvalid <= 1'b0;
    end
    do @(negedge clk); while (!s_bvalid);
    rs = s_bresp;
    @(posedge clk);
    s_bready <= 1'b0;
    @(negedge clk);
  endtask : axw
  // bus read
  task automatic axr(input logic [3:0] a);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge clk); while (!s_arready);
    @(posedge clk);
    s_arvalid <= 1'b0;
    do @(negedge clk); while (!s_rvalid);
    rd = s_rdata;
    rs = s_rresp;
    @(posedge clk);
    s_rready <= 1'b0;
    @(negedge clk);
  endtask : axr
  // set the force pins
  task automatic pins(input logic p, input logic c);
    @(posedge clk);
    async_preset_n <= p;
    async_clear_n <= c;
    @(negedge clk);
  endtask : pins
  // one bank clock change with given enables and data, then settle
  task automatic tick(input logic re, input logic fe,
                      input logic [7:0] d, input logic [7:0] j,
                      input logic [7:0] k);
    @(posedge clk);
    rise_edge_enable <= re;
    fall_edge_enable <= fe;
    d_in <= d;
    j_in <= j;
    k_in <= k;
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : tick
  // forcing pins
  task automatic t_force();
    pins(1'b1, 1'b0);
    chk(outs, 32'h00FFFF00);
    pins(1'b0, 1'b1);
    chk(outs, 32'hFF00FF00);
    pins(1'b0, 1'b0);
    chk(outs & 32'hFFFF00FF, 32'hFFFF0001);
    axr(EFB_ADDR_STATUS);
    chk(rd, 32'h00000001);
    pins(1'b1, 1'b1);
    chk(outs, 32'hFF000000);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    chk(outs, 32'h00FFFF00);
  endtask : t_force
  // rising d bank
  task automatic t_rise_d();
    tick(1'b0, 1'b0, 8'hA5, 8'h00, 8'h00);
    chk(outs, 32'hA55AFF00);
    tick(1'b0, 1'b0, 8'h5A, 8'h00, 8'h00);
    chk(outs, 32'hA55AFF00);
  endtask : t_rise_d
  // falling jk bank, all four actions at once
  task automatic t_fall_jk();
    axw(EFB_ADDR_CTRL, 32'(EFB_FALL_JK));
    chk(32'(rs), 32'(EFB_RESP_OKAY));
    tick(1'b0, 1'b0, 8'h00, 8'hF0, 8'hCC);
    chk(outs, 32'hA55AFF00);
    tick(1'b0, 1'b0, 8'h00, 8'hF0, 8'hCC);
    chk(outs, 32'h718EFF00);
  endtask : t_fall_jk
  // dual d bank, enables off, fall only and rise only
  task automatic t_dual_d();
    axw(EFB_ADDR_CTRL, 32'(EFB_DUAL_D));
    tick(1'b0, 1'b0, 8'h3C, 8'h00, 8'h00);
    chk(outs, 32'h718EFF00);
    tick(1'b0, 1'b1, 8'h3C, 8'h00, 8'h00);
    chk(outs, 32'h3CC3FF00);
    tick(1'b0, 1'b1, 8'hC3, 8'h00, 8'h00);
    chk(outs, 32'h3CC3FF00);
    tick(1'b1, 1'b0, 8'hC3, 8'h00, 8'h00);
    chk(outs, 32'h3CC3FF00);
    tick(1'b1, 1'b0, 8'hC3, 8'h00, 8'h00);
    chk(outs, 32'hC33CFF00);
  endtask : t_dual_d
  // dual jk bank toggle on enabled edge only
  task automatic t_dual_jk();
    axw(EFB_ADDR_CTRL, 32'(EFB_DUAL_JK));
    tick(1'b1, 1'b0, 8'h00, 8'hFF, 8'hFF);
    chk(outs, 32'hC33CFF00);
    tick(1'b1, 1'b0, 8'h00, 8'hFF, 8'hFF);
    chk(outs, 32'h3CC3FF00);
  endtask : t_dual_jk
  // register map: read-only state, unmapped place
  task automatic t_bus();
    axw(EFB_ADDR_STATE, 32'h000000FF);
    chk(32'(rs), 32'(EFB_RESP_OKAY));
    axr(EFB_ADDR_STATE);
    chk(rd, 32'h0000003C);
    axr(4'h2);
    chk({rd[29:0], rs}, 32'(EFB_RESP_SLVERR));
    axr(EFB_ADDR_CTRL);
    chk(rd, 32'(EFB_DUAL_JK));
    // unmapped write answers an error
    axw(4'h2, 32'h00000000);
    chk(32'(rs), 32'(EFB_RESP_SLVERR));
    // low byte lane off: variant must not move
    @(posedge clk);
    s_wstrb <= 4'hE;
    axw(EFB_ADDR_CTRL, 32'(EFB_RISE_D));
    chk(32'(rs), 32'(EFB_RESP_OKAY));
    @(posedge clk);
    s_wstrb <= 4'hF;
    axr(EFB_ADDR_CTRL);
    chk(rd, 32'(EFB_DUAL_JK));
  endtask : t_bus
  // main sequence
  initial begin
    {rst_n, step, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, rise_edge_enable, fall_edge_enable} = '0;
    {s_awaddr, s_araddr, s_wdata, d_in, j_in, k_in} = '0;
    s_wstrb = 4'hF;
    async_preset_n = 1'b1;
    async_clear_n = 1'b1;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'(bit_known), 32'h0);
    axr(EFB_ADDR_CTRL);
    chk(rd, 32'(EFB_CTRL_RESET));
    t_force();
    t_rise_d();
    t_fall_jk();
    t_dual_d();
    t_dual_jk();
    t_bus();
    wrap_up();
  end
endmodule : test_edge_flip_flop_bank
